// [src/dcfsm_params.svh]
// Constants of the single-clock FIFO with synchronous-mode option
`ifndef DCFSM_PARAMS_SVH
`define DCFSM_PARAMS_SVH

// Word layout of the widest configuration, 512 nominal entries by 72 bits
`define DCFSM_DATA_W 64
`define DCFSM_PAR_W 8
`define DCFSM_PTR_W 10
`define DCFSM_OFF_W 13
`define DCFSM_REL_W 3

// Storage entries: nominal depth plus the extra standard-mode entry
`define DCFSM_STORE_ENTRIES 513
`define DCFSM_PTR_MAX 10'h200
`define DCFSM_PTR_ZERO 10'h000
`define DCFSM_CNT_ZERO 10'h000
`define DCFSM_CAP_STD 10'h201
`define DCFSM_CAP_EARLY_HEAD_PRESENT_MODE 10'h202

// Option values after reset, used until the options are captured
`define DCFSM_SYNC_RST 1'b1
`define DCFSM_EARLY_HEAD_PRESENT_MODE_RST 1'b0
`define DCFSM_PIPE_RST 1'b0
`define DCFSM_NEAR_EMPTY_OFF_RST 13'h0080
`define DCFSM_NEAR_FULL_OFF_RST 13'h0080
`define DCFSM_OFF_ONE 13'h0001

// Flag timing counts in clock cycles for the multirate path
`define DCFSM_REL_NONE 3'h0
`define DCFSM_REL_EMPTY_STD 3'h3
`define DCFSM_REL_EMPTY_EARLY_HEAD_PRESENT_MODE 3'h4
`define DCFSM_REL_FULL 3'h3
`define DCFSM_REL_NEAR 3'h3
`define DCFSM_REL_ONE 3'h1
`define DCFSM_ASSERT_NEAR_LATE 1'b1

`endif

// [src/dcfsm_pkg.sv]
// Types shared by the single-clock FIFO modules
`include "dcfsm_params.svh"
package dcfsm_pkg;
   typedef logic [`DCFSM_DATA_W-1:0] dcfsm_word_t;
   typedef logic [`DCFSM_PAR_W-1:0] dcfsm_par_t;
   typedef logic [`DCFSM_PTR_W-1:0] dcfsm_ptr_t;
   typedef logic [`DCFSM_PTR_W-1:0] dcfsm_cnt_t;
   typedef logic [`DCFSM_OFF_W-1:0] dcfsm_off_t;
   typedef logic [`DCFSM_REL_W-1:0] dcfsm_rel_t;
endpackage

// [src/dcfsm_store.sv]
// Flip-flop storage array with one write port and one indexed read port
`timescale 1ns/1ps
`include "dcfsm_params.svh"
module dcfsm_store (
   input wire logic clk,
   input wire logic write_go,
   input wire dcfsm_pkg::dcfsm_ptr_t write_index,
   input wire logic [`DCFSM_DATA_W+`DCFSM_PAR_W-1:0] write_entry,
   input wire dcfsm_pkg::dcfsm_ptr_t read_index,
   output logic [`DCFSM_DATA_W+`DCFSM_PAR_W-1:0] read_entry
);
   logic [`DCFSM_DATA_W+`DCFSM_PAR_W-1:0] mem [0:`DCFSM_STORE_ENTRIES-1];

   // One enable per entry; no reset, so contents survive a FIFO reset
   for (genvar i = 0; i < `DCFSM_STORE_ENTRIES; i++) begin : g_entry
      // Cut the loop index to pointer width on purpose; every entry fits
      localparam dcfsm_pkg::dcfsm_ptr_t ENTRY_INDEX = dcfsm_pkg::dcfsm_ptr_t'(i);
      always_ff @(posedge clk) begin
         if (write_go && (write_index == ENTRY_INDEX)) begin
            mem[i] <= write_entry;
         end
      end
   end

   // Index never passes the last entry, the pointers wrap to zero after it
   assign read_entry = mem[read_index];
endmodule

// [src/dcfsm_flag_delay.sv]
// Status flag shaper: optional one-cycle rise and counted release
`timescale 1ns/1ps
`include "dcfsm_params.svh"
module dcfsm_flag_delay #(
   parameter logic RESET_HELD = 1'b0
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic raw,
   input wire logic assert_late,
   input wire dcfsm_pkg::dcfsm_rel_t release_cycles,
   output logic flag_out
);
   logic held;
   dcfsm_pkg::dcfsm_rel_t low_count;
   dcfsm_pkg::dcfsm_rel_t next_low_count;
   logic stretch_on;
   logic release_now;

   // Holding only matters when some latency is configured at all
   assign stretch_on = assert_late | (release_cycles != `DCFSM_REL_NONE);
   assign next_low_count = low_count + `DCFSM_REL_ONE;
   assign release_now = (next_low_count >= release_cycles);
   assign flag_out = (raw & ~assert_late) | (held & stretch_on);

   // A new rise restarts the count, so a short dip never escapes early
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         held <= RESET_HELD;
         low_count <= `DCFSM_REL_NONE;
      end else if (raw) begin
         held <= 1'b1;
         low_count <= `DCFSM_REL_NONE;
      end else if (held) begin
         held <= ~release_now;
         low_count <= release_now ? `DCFSM_REL_NONE : next_low_count;
      end
   end
endmodule

// [src/dcfsm_fifo.sv]
// Single-clock FIFO with synchronous-mode, fall-through and pipeline options
`timescale 1ns/1ps
`include "dcfsm_params.svh"
module dcfsm_fifo (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic sync_mode_select,
   input wire logic early_head_present_mode,
   input wire logic out_pipe_select,
   input wire dcfsm_pkg::dcfsm_off_t near_full_offset,
   input wire dcfsm_pkg::dcfsm_off_t near_empty_offset,
   input wire logic write_enable,
   input wire dcfsm_pkg::dcfsm_word_t write_word_in,
   input wire dcfsm_pkg::dcfsm_par_t write_parity_in,
   input wire logic read_enable,
   output dcfsm_pkg::dcfsm_word_t read_word_out,
   output dcfsm_pkg::dcfsm_par_t read_parity_out,
   output logic full_flag,
   output logic empty_flag,
   output logic near_full_flag,
   output logic near_empty_flag,
   output dcfsm_pkg::dcfsm_ptr_t read_pointer_out,
   output dcfsm_pkg::dcfsm_ptr_t write_pointer_out,
   output logic write_overflow_flag,
   output logic read_underflow_flag
);
   // Captured options
   logic cfg_taken;
   logic cfg_sync;
   logic cfg_early_head_present_mode_req;
   logic cfg_pipe;
   dcfsm_pkg::dcfsm_off_t cfg_near_full_off;
   dcfsm_pkg::dcfsm_off_t cfg_near_empty_off;

   // Queue state
   dcfsm_pkg::dcfsm_ptr_t write_ptr;
   dcfsm_pkg::dcfsm_ptr_t read_ptr;
   dcfsm_pkg::dcfsm_cnt_t store_count;
   logic head_valid;
   dcfsm_pkg::dcfsm_ptr_t next_write_ptr;
   dcfsm_pkg::dcfsm_ptr_t next_read_ptr;
   dcfsm_pkg::dcfsm_cnt_t next_store_count;
   logic next_head_valid;

   // Output data registers
   logic [`DCFSM_DATA_W+`DCFSM_PAR_W-1:0] out_entry;
   logic [`DCFSM_DATA_W+`DCFSM_PAR_W-1:0] pipe_entry;
   logic [`DCFSM_DATA_W+`DCFSM_PAR_W-1:0] store_head;
   logic [`DCFSM_DATA_W+`DCFSM_PAR_W-1:0] shown_entry;

   // Decoded control
   logic early_head_present_mode_on;
   logic write_go;
   logic read_take;
   logic pop_store;
   logic store_empty;
   logic store_full;
   dcfsm_pkg::dcfsm_cnt_t capacity;
   dcfsm_pkg::dcfsm_cnt_t total_count;
   dcfsm_pkg::dcfsm_cnt_t free_count;
   logic empty_raw;
   logic full_raw;
   logic near_empty_raw;
   logic near_full_raw;
   logic near_empty_state;
   logic near_full_state;
   logic empty_late;
   logic full_late;
   logic near_empty_late;
   logic near_full_late;
   dcfsm_pkg::dcfsm_rel_t empty_release;
   dcfsm_pkg::dcfsm_rel_t full_release;
   dcfsm_pkg::dcfsm_rel_t near_release;
   logic near_assert_late;
   dcfsm_pkg::dcfsm_off_t total_wide;
   dcfsm_pkg::dcfsm_off_t free_wide;

   // Options are caught once, at the first edge after reset release,
   // so a change on the pins mid-run cannot corrupt flag arithmetic
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         cfg_taken <= 1'b0;
         cfg_sync <= `DCFSM_SYNC_RST;
         cfg_early_head_present_mode_req <= `DCFSM_EARLY_HEAD_PRESENT_MODE_RST;
         cfg_pipe <= `DCFSM_PIPE_RST;
         cfg_near_full_off <= `DCFSM_NEAR_FULL_OFF_RST;
         cfg_near_empty_off <= `DCFSM_NEAR_EMPTY_OFF_RST;
      end else if (!cfg_taken) begin
         cfg_taken <= 1'b1;
         cfg_sync <= sync_mode_select;
         cfg_early_head_present_mode_req <= early_head_present_mode;
         cfg_pipe <= out_pipe_select;
         cfg_near_full_off <= near_full_offset;
         cfg_near_empty_off <= near_empty_offset;
      end
   end

   // Mode decode
   assign early_head_present_mode_on = cfg_early_head_present_mode_req & ~cfg_sync;
   // Fall-through adds the head register as a second extra entry
   assign capacity = early_head_present_mode_on ? `DCFSM_CAP_EARLY_HEAD_PRESENT_MODE : `DCFSM_CAP_STD;

   // Storage occupancy; the array holds nominal depth plus one words
   assign store_empty = (store_count == `DCFSM_CNT_ZERO);
   assign store_full = (store_count == `DCFSM_CAP_STD);

   // Accesses are refused on the shaped flags, which are never late on
   // their rising edge, so the storage can never over- or under-run
   assign write_go = write_enable & ~full_flag;
   assign read_take = read_enable & ~empty_flag;

   // In fall-through mode the head register refills itself from storage
   assign pop_store = early_head_present_mode_on ? (~store_empty & (~head_valid | read_take)) :
                      read_take;

   // Pointer and count updates
   assign next_write_ptr = (write_ptr == `DCFSM_PTR_MAX) ? `DCFSM_PTR_ZERO :
                           write_ptr + 10'h001;
   assign next_read_ptr = (read_ptr == `DCFSM_PTR_MAX) ? `DCFSM_PTR_ZERO :
                          read_ptr + 10'h001;
   assign next_store_count = store_count + {9'h000, write_go} - {9'h000, pop_store};
   assign next_head_valid = pop_store ? 1'b1 : (read_take ? 1'b0 : head_valid);

   // Pointers and counts clear asynchronously; data registers do not
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         write_ptr <= `DCFSM_PTR_ZERO;
         read_ptr <= `DCFSM_PTR_ZERO;
         store_count <= `DCFSM_CNT_ZERO;
         head_valid <= 1'b0;
      end else begin
         if (write_go) begin
            write_ptr <= next_write_ptr;
         end
         if (pop_store) begin
            read_ptr <= next_read_ptr;
         end
         store_count <= next_store_count;
         head_valid <= early_head_present_mode_on & next_head_valid;
      end
   end

   // Storage array, written with word and parity side by side
   dcfsm_store u_store (
      .clk(clk),
      .write_go(write_go),
      .write_index(write_ptr),
      .write_entry({write_parity_in, write_word_in}),
      .read_index(read_ptr),
      .read_entry(store_head)
   );

   // Output register loads only on a pop, so an idle read holds the word;
   // it has no reset at all, so a FIFO reset leaves the last word visible
   always_ff @(posedge clk) begin
      if (pop_store) begin
         out_entry <= store_head;
      end
   end

   // Extra pipeline stage: faster clock-to-out at one cycle of latency
   always_ff @(posedge clk) begin
      pipe_entry <= out_entry;
   end

   // Data selection between the two registered stages
   assign shown_entry = cfg_pipe ? pipe_entry : out_entry;
   assign read_word_out = shown_entry[`DCFSM_DATA_W-1:0];
   assign read_parity_out = shown_entry[`DCFSM_DATA_W+`DCFSM_PAR_W-1:`DCFSM_DATA_W];

   // Occupancy as seen by the user, head register included
   assign total_count = store_count + {9'h000, head_valid};
   assign free_count = capacity - total_count;
   assign total_wide = {3'h0, total_count};
   assign free_wide = {3'h0, free_count};

   // Raw flag conditions computed from registered state, so in
   // synchronous mode they change at the very edge of the access
   assign empty_raw = early_head_present_mode_on ? ~head_valid : store_empty;
   assign full_raw = store_full;

   // Near flags set at or below the offset and clear above offset plus one
   assign near_empty_raw = (total_wide <= cfg_near_empty_off) |
      (near_empty_state & (total_wide <= (cfg_near_empty_off + `DCFSM_OFF_ONE)));
   assign near_full_raw = (free_wide <= cfg_near_full_off) |
      (near_full_state & (free_wide <= (cfg_near_full_off + `DCFSM_OFF_ONE)));

   // Hysteresis memory of the near flags
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         near_empty_state <= 1'b1;
         near_full_state <= 1'b0;
      end else begin
         near_empty_state <= near_empty_raw;
         near_full_state <= near_full_raw;
      end
   end

   // Flag timing per mode: zero everywhere in synchronous mode, the
   // multirate figures otherwise; the rise of full and empty is never late
   assign empty_release = cfg_sync ? `DCFSM_REL_NONE :
      (early_head_present_mode_on ? `DCFSM_REL_EMPTY_EARLY_HEAD_PRESENT_MODE : `DCFSM_REL_EMPTY_STD);
   assign full_release = cfg_sync ? `DCFSM_REL_NONE : `DCFSM_REL_FULL;
   assign near_release = cfg_sync ? `DCFSM_REL_NONE : `DCFSM_REL_NEAR;
   assign near_assert_late = ~cfg_sync & `DCFSM_ASSERT_NEAR_LATE;

   // Empty flag shaper
   dcfsm_flag_delay #(
      .RESET_HELD(1'b1)
   ) u_empty_delay (
      .clk(clk),
      .reset_n(reset_n),
      .raw(empty_raw),
      .assert_late(1'b0),
      .release_cycles(empty_release),
      .flag_out(empty_late)
   );

   // Full flag shaper
   dcfsm_flag_delay #(
      .RESET_HELD(1'b0)
   ) u_full_delay (
      .clk(clk),
      .reset_n(reset_n),
      .raw(full_raw),
      .assert_late(1'b0),
      .release_cycles(full_release),
      .flag_out(full_late)
   );

   // Near-empty flag shaper
   dcfsm_flag_delay #(
      .RESET_HELD(1'b1)
   ) u_near_empty_delay (
      .clk(clk),
      .reset_n(reset_n),
      .raw(near_empty_raw),
      .assert_late(near_assert_late),
      .release_cycles(near_release),
      .flag_out(near_empty_late)
   );

   // Near-full flag shaper
   dcfsm_flag_delay #(
      .RESET_HELD(1'b0)
   ) u_near_full_delay (
      .clk(clk),
      .reset_n(reset_n),
      .raw(near_full_raw),
      .assert_late(near_assert_late),
      .release_cycles(near_release),
      .flag_out(near_full_late)
   );

   // Flags are forced straight from the reset pin, without waiting for
   // an edge, so the user sees them safe during the whole reset
   assign empty_flag = empty_late | ~reset_n;
   assign near_empty_flag = near_empty_late | ~reset_n;
   assign full_flag = full_late & reset_n;
   assign near_full_flag = near_full_late & reset_n;

   // Error flags follow the offending attempt and drop as soon as the
   // enable or the blocking flag goes low; refused accesses move nothing
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         write_overflow_flag <= 1'b0;
         read_underflow_flag <= 1'b0;
      end else begin
         write_overflow_flag <= write_enable & full_flag;
         read_underflow_flag <= read_enable & empty_flag;
      end
   end

   // Pointer outputs straight from the pointer registers
   assign read_pointer_out = read_ptr;
   assign write_pointer_out = write_ptr;
endmodule

// [tb/dcfsm_fifo_properties.sv]
// Concurrent checks on the FIFO ports
`timescale 1ns/1ps
module dcfsm_fifo_properties (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic write_enable,
   input wire logic read_enable,
   input wire logic full_flag,
   input wire logic empty_flag,
   input wire logic near_full_flag,
   input wire logic near_empty_flag,
   input wire dcfsm_pkg::dcfsm_ptr_t write_pointer_out,
   input wire dcfsm_pkg::dcfsm_ptr_t read_pointer_out,
   input wire logic write_overflow_flag,
   input wire logic read_underflow_flag
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   // Refused accesses raise the error flag and freeze the pointer
   property p_wr_refused;
      write_enable && full_flag |=> write_overflow_flag && $stable(write_pointer_out);
   endproperty
   a_wr_refused: assert property (p_wr_refused) else $error("bad refused write");
   property p_rd_refused;
      read_enable && empty_flag |=> read_underflow_flag && $stable(read_pointer_out);
   endproperty
   a_rd_refused: assert property (p_rd_refused) else $error("bad refused read");
   // Error flags drop once the enable or the flag is low
   property p_wr_err_clear;
      !write_enable || !full_flag |=> !write_overflow_flag;
   endproperty
   a_wr_err_clear: assert property (p_wr_err_clear) else $error("write error stuck");
   property p_rd_err_clear;
      !read_enable || !empty_flag |=> !read_underflow_flag;
   endproperty
   a_rd_err_clear: assert property (p_rd_err_clear) else $error("read error stuck");
   // Accepted accesses step the pointer, wrapping after the top entry
   property p_wr_step;
      write_enable && !full_flag |=> write_pointer_out == (($past(write_pointer_out) == 10'h200)
         ? 10'h000 : $past(write_pointer_out) + 10'h001);
   endproperty
   a_wr_step: assert property (p_wr_step) else $error("write pointer step");
   property p_rd_step;
      read_enable && !empty_flag |=> read_pointer_out == (($past(read_pointer_out) == 10'h200)
         ? 10'h000 : $past(read_pointer_out) + 10'h001);
   endproperty
   a_rd_step: assert property (p_rd_step) else $error("read pointer step");
   // Reset levels hold for the whole reset, so this one is not disabled by it
   property p_rst_flags;
      disable iff (1'b0) !reset_n |-> empty_flag && near_empty_flag && !full_flag && !near_full_flag;
   endproperty
   a_rst_flags: assert property (p_rst_flags) else $error("flags wrong in reset");
   property p_full_near;
      full_flag |-> near_full_flag && !empty_flag;
   endproperty
   a_full_near: assert property (p_full_near) else $error("full without near full");
   // Synchronous mode: one write into an empty queue clears empty at once
   property p_no_latency;
      empty_flag && write_enable && !read_enable |=> !empty_flag;
   endproperty
   a_no_latency: assert property (p_no_latency) else $error("empty flag late");
endmodule

// [tb/dcfsm_user.sv]
// Producer and consumer user logic on the FIFO ports
`timescale 1ns/1ps
module dcfsm_user (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic want_write,
   input wire logic want_read,
   output logic write_enable,
   output dcfsm_pkg::dcfsm_word_t write_word_in,
   output dcfsm_pkg::dcfsm_par_t write_parity_in,
   output logic read_enable
);
   // Enables held low in reset; data changes every cycle so stale words show
   always @(posedge clk or negedge reset_n) begin
      write_word_in <= {$urandom, $urandom};
      write_parity_in <= 8'($urandom);
      if (!reset_n) begin
         write_enable <= 1'b0;
         read_enable <= 1'b0;
      end else begin
         write_enable <= want_write;
         read_enable <= want_read;
      end
   end
endmodule

// [tb/test_dual_clock_fifo_sync_mode.sv]
// Self-checking bench for the FIFO with a queue model
`timescale 1ns/1ps
module test_dual_clock_fifo_sync_mode;
   logic clk, reset_n, sync_mode_select, early_head_present_mode, out_pipe_select;
   logic want_write, want_read, write_enable, read_enable, full_flag, empty_flag;
   logic near_full_flag, near_empty_flag, write_overflow_flag, read_underflow_flag;
   dcfsm_pkg::dcfsm_off_t near_full_offset, near_empty_offset;
   dcfsm_pkg::dcfsm_word_t write_word_in, read_word_out;
   dcfsm_pkg::dcfsm_par_t write_parity_in, read_parity_out;
   dcfsm_pkg::dcfsm_ptr_t read_pointer_out, write_pointer_out;
   int errors, checks, cnt, wp, rp, ne, nf, wo, ru, cap, pipe_c, nfo, neo;
   logic [71:0] s1, s2, q[$];
   bit v1, v2;
   dcfsm_fifo dut_u (.clk, .reset_n, .sync_mode_select, .early_head_present_mode,
      .out_pipe_select, .near_full_offset, .near_empty_offset, .write_enable,
      .write_word_in, .write_parity_in, .read_enable, .read_word_out, .read_parity_out,
      .full_flag, .empty_flag, .near_full_flag, .near_empty_flag, .read_pointer_out,
      .write_pointer_out, .write_overflow_flag, .read_underflow_flag);
   dcfsm_user user_u (.clk, .reset_n, .want_write, .want_read, .write_enable,
      .write_word_in, .write_parity_in, .read_enable);
   always #12.5 clk = ~clk;
   task automatic chk(input string n, input logic [63:0] seen, input logic [63:0] exp);
      checks++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch %s expected %h seen %h", n, exp, seen);
      end
   endtask
   task automatic complete_run;
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // Drive the user requests; 2 means a random choice each cycle
   task automatic run(input int w, input int r, input int n, input string name);
      repeat (n) begin
         @(posedge clk);
         want_write <= (w == 2) ? 1'($urandom % 2) : 1'(w);
         want_read <= (r == 2) ? 1'($urandom % 2) : 1'(r);
      end
      $display("test %s done", name);
   endtask
   // Model sees pre-edge values: compare this cycle, then step the queue
   always @(posedge clk) begin
      if (!reset_n) begin
         chk("empty_rst", {empty_flag, near_empty_flag, full_flag, near_full_flag}, 4'hc);
         q.delete();
         {cnt, wp, rp, wo, ru, cap, nf, v2} = '0;
         ne = 1;
      end else begin
         chk("full", full_flag, cnt == 513);
         chk("empty", empty_flag, cnt == 0);
         chk("near", {near_full_flag, near_empty_flag}, {1'(nf), 1'(ne)});
         chk("wptr", write_pointer_out, wp);
         chk("rptr", read_pointer_out, rp);
         chk("errs", {write_overflow_flag, read_underflow_flag}, {1'(wo), 1'(ru)});
         if (cap && (pipe_c ? v2 : v1)) begin
            chk("word", read_word_out, pipe_c ? s2[63:0] : s1[63:0]);
            chk("parity", read_parity_out, pipe_c ? s2[71:64] : s1[71:64]);
         end
         if (!cap) begin
            {cap, pipe_c, nfo, neo} = {32'd1, 32'(out_pipe_select), 32'(near_full_offset),
               32'(near_empty_offset)};
         end
         {s2, v2} = {s1, v1};
         wo = write_enable && cnt == 513;
         ru = read_enable && cnt == 0;
         if (read_enable && cnt > 0) begin
            s1 = q.pop_front();
            v1 = 1;
            rp = (rp + 1) % 513;
         end
         if (write_enable && cnt < 513) begin
            q.push_back({write_parity_in, write_word_in});
            wp = (wp + 1) % 513;
         end
         cnt = q.size();
         if (cnt <= neo) ne = 1;
         else if (cnt > neo + 1) ne = 0;
         if (513 - cnt <= nfo) nf = 1;
         else if (513 - cnt > nfo + 1) nf = 0;
      end
   end
   // Main sequence: fill past full, drain past empty, then reset with pipeline on
   initial begin
      void'($urandom(29));
      {clk, reset_n, early_head_present_mode, out_pipe_select, want_write, want_read} = '0;
      sync_mode_select = 1'b1;
      near_full_offset = 13'($urandom_range(2, 300));
      near_empty_offset = 13'($urandom_range(2, 300));
      repeat (12) @(posedge clk);
      reset_n <= 1'b1;
      run(1, 0, 520, "fill");
      run(0, 1, 520, "drain");
      run(2, 2, 400, "mixed");
      run(1, 0, 20, "partial");
      @(posedge clk);
      {want_write, want_read, reset_n} <= '0;
      out_pipe_select <= 1'b1;
      early_head_present_mode <= 1'b1;
      near_empty_offset <= 13'($urandom_range(2, 300));
      repeat (3) @(posedge clk);
      reset_n <= 1'b1;
      run(1, 0, 10, "reset keeps data");
      run(0, 1, 12, "pipeline drain");
      run(2, 2, 400, "mixed pipeline");
      complete_run();
   end
   // Hang guard
   initial begin
      #125000;
      errors++;
      complete_run();
   end
endmodule
bind dcfsm_fifo dcfsm_fifo_properties props_u (.clk, .reset_n, .write_enable, .read_enable,
   .full_flag, .empty_flag, .near_full_flag, .near_empty_flag, .write_pointer_out,
   .read_pointer_out, .write_overflow_flag, .read_underflow_flag);
